/* logic/asfd_regs.svh */
/*
  Register indices, field positions, reset values and frame lengths of the
  serial port flag and data block.
  Assumes it is included by its bare name wherever these names are used.
*/
//
// Contract
// R1: Enable-control register, eight bits, reset zero.
// R2: Empty flag with its enable raises interrupt.
// R3: Complete flag with its enable raises interrupt.
// R4: Receive enable gates full or overrun interrupt.
// R5: Quiet enable gates the line-quiet interrupt.
// R6: Wakeup bit waits receiver, blocks receive interrupts.
// R7: Break bit sends break frames continuously.
// R8: Primary status flags, reset with transmit flags.
// R9: Empty flag cleared by status read, data write.
// R10: Complete flag set idle, cleared like empty.
// R11: Full flag set on transfer, status-then-data read.
// R12: Quiet flag once per activity, blocked in wakeup.
// R13: Overrun discards new character, keeps buffered one.
// R14: Noise flag from split majority vote.
// R15: Framing flag on zero stop bit.
// R16: Parity flag on wrong parity.
// R17: Noise, framing, parity never interrupt.
// R18: Second status shows receiver active, rest zero.
// R19: Data pair double buffered, high unused bits zero.
// R20: High byte carries received and sent ninth bits.
// R21: Enabling transmitter sets empty and complete flags.
// R22: Disabling transmitter finishes character, drops queue.
// R23: Frame is start, eight or nine, stop.
// R24: Software writes high data byte before low.
// R25: One level interrupt from all enabled sources.
`ifndef ASFD_REGS_SVH
`define ASFD_REGS_SVH

`define ASFD_IDX_CFG 8'h72
`define ASFD_IDX_CTRL 8'h73
`define ASFD_IDX_STAT1 8'h74
`define ASFD_IDX_STAT2 8'h75
`define ASFD_IDX_DHI 8'h76
`define ASFD_IDX_DLO 8'h77

`define ASFD_C_TXE_IEN 7
`define ASFD_C_TXC_IEN 6
`define ASFD_C_RX_IEN 5
`define ASFD_C_QUIET_IEN 4
`define ASFD_C_TX_ON 3
`define ASFD_C_RX_ON 2
`define ASFD_C_WAKE 1
`define ASFD_C_BREAK 0

`define ASFD_S_TXE 7
`define ASFD_S_TXC 6
`define ASFD_S_RXF 5
`define ASFD_S_IDLE 4
`define ASFD_S_OR 3
`define ASFD_S_NOISE 2
`define ASFD_S_FRAME 1
`define ASFD_S_PARITY 0

`define ASFD_F_NINE 4
`define ASFD_F_PEN 1
`define ASFD_F_PODD 0

`define ASFD_D_RX9 7
`define ASFD_D_TX9 6

`define ASFD_RST_CTRL 8'h00
`define ASFD_RST_STAT1 8'hc0
`define ASFD_RST_CFG 8'h00
`define ASFD_RX_MASK 8'h3f
`define ASFD_TX_MASK 8'hc0

`define ASFD_LEN8 4'ha
`define ASFD_LEN9 4'hb
`define ASFD_FRAME_ONES 11'h7ff
`define ASFD_FRAME_ZERO 11'h000

`endif

/* logic/asfd_pkg.sv */
/*
  Types shared by the serial port flag and data block.
  Assumes the register header supplies all numeric constants.
*/
package asfd_pkg;

  typedef enum logic [0:0] {ASFD_TX_IDLE, ASFD_TX_SHIFT} asfd_tx_state_e;

  typedef struct packed {
    asfd_tx_state_e state;
    logic [10:0] shreg;
    logic [3:0] cnt;
    logic pin_owned;
    logic txd;
  } asfd_tx_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic seen_active;
    logic pulse;
  } asfd_quiet_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] flags;
    logic [7:0] armed;
    logic [8:0] rx_buf;
    logic [7:0] tx_buf;
    logic tx_ninth;
    logic tx_buf_full;
    logic preamble_pend;
    logic tx_busy_d;
    logic rx_active;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } asfd_top_s;

endpackage : asfd_pkg

/* logic/asfd_tx_shifter.sv */
/*
  Transmit shift register: sends one loaded frame LSB first, one bit per
  bit tick, and owns the transmit pin while the transmitter is enabled.
  Assumes the bit tick is a one-cycle pulse from an outside rate divider.
*/
`timescale 1ns/100ps
`include "asfd_regs.svh"

module asfd_tx_shifter (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic bit_tick,
  input wire logic transmitter_on,
  input wire logic load,
  input wire logic [10:0] frame,
  input wire logic [3:0] frame_len,
  output logic busy,
  output logic txd,
  output logic txd_oe_n
);
  import asfd_pkg::*;

  asfd_tx_s s_ff;
  asfd_tx_s nxt_s;

  // Loads a frame, shifts it out and releases the pin on a bit tick.
  always_comb begin
    nxt_s = s_ff;
    if (transmitter_on) begin
      nxt_s.pin_owned = 1'b1;
    end else if (bit_tick && s_ff.state == ASFD_TX_IDLE) begin
      nxt_s.pin_owned = 1'b0; // [R22]
    end
    case (s_ff.state)
      ASFD_TX_IDLE: begin
        if (load) begin
          nxt_s.shreg = frame;
          nxt_s.cnt = frame_len;
          nxt_s.state = ASFD_TX_SHIFT;
        end
      end
      ASFD_TX_SHIFT: begin
        if (bit_tick) begin
          if (s_ff.cnt == 4'h0) begin
            nxt_s.state = ASFD_TX_IDLE;
            nxt_s.txd = 1'b1;
          end else begin
            nxt_s.txd = s_ff.shreg[0];
            nxt_s.shreg = {1'b1, s_ff.shreg[10:1]};
            nxt_s.cnt = s_ff.cnt - 4'h1;
          end
        end
      end
      default: nxt_s.state = ASFD_TX_IDLE;
    endcase
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '{state: ASFD_TX_IDLE, shreg: `ASFD_FRAME_ONES, cnt: 4'h0, pin_owned: 1'b0, txd: 1'b1};
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign busy = (s_ff.state == ASFD_TX_SHIFT);
  assign txd = s_ff.txd;
  assign txd_oe_n = ~s_ff.pin_owned;

endmodule : asfd_tx_shifter

/* logic/asfd_quiet_detect.sv */
/*
  Line-quiet detector: pulses once when the receive line, after being
  active, has stayed high for a full character time of bit ticks.
  Assumes the receive line input is synchronous to the clock.
*/
`timescale 1ns/100ps
`include "asfd_regs.svh"

module asfd_quiet_detect (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic bit_tick,
  input wire logic rxd,
  input wire logic [3:0] frame_len,
  output logic quiet_pulse
);
  import asfd_pkg::*;

  asfd_quiet_s s_ff;
  asfd_quiet_s nxt_s;

  // Counts high bit times; only an earlier low level re-arms the pulse.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.pulse = 1'b0;
    if (!enable) begin
      nxt_s.cnt = 4'h0;
      nxt_s.seen_active = 1'b0;
    end else if (bit_tick) begin
      if (!rxd) begin
        nxt_s.cnt = 4'h0;
        nxt_s.seen_active = 1'b1;
      end else if (s_ff.seen_active) begin
        if (s_ff.cnt == frame_len - 4'h1) begin
          nxt_s.pulse = 1'b1; // [R12]
          nxt_s.seen_active = 1'b0;
          nxt_s.cnt = 4'h0;
        end else begin
          nxt_s.cnt = s_ff.cnt + 4'h1;
        end
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '{cnt: 4'h0, seen_active: 1'b0, pulse: 1'b0};
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign quiet_pulse = s_ff.pulse;

endmodule : asfd_quiet_detect

/* logic/asfd_top.sv */
/*
  Serial port flag, control and data buffer block: enable control, status
  flags with their read-then-access clearing, double-buffered data and a
  single interrupt request, reached over an Avalon-MM slave.
  Assumes an outside bit-rate divider gives bit_tick and an outside
  receive sampler delivers each whole character with its noise and stop
  bit; all inputs are synchronous to clock.
*/
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "asfd_regs.svh"

module asfd_top #(
  parameter int ADDR_W = 10
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bit_tick,
  input wire logic rxd,
  input wire logic rx_char_strobe,
  input wire logic [8:0] rx_char_bits,
  input wire logic rx_char_noise,
  input wire logic rx_char_stop_bit,
  input wire logic rx_busy,
  output logic txd_out,
  output logic txd_oe_n,
  output logic irq
);
  import asfd_pkg::*;

  // The register map needs byte addresses up to four times the top index.
  if (ADDR_W < 9) begin : g_addr_check
    $error("ADDR_W too small for the register map.");
  end

  asfd_top_s s_ff;
  asfd_top_s nxt_s;

  logic tx_busy;
  logic quiet_pulse;
  logic load_now;
  logic [10:0] load_frame;
  logic [3:0] frame_len;

  // True when a byte address selects the register at the given index.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    logic [ADDR_W-1:0] want;
    want = ADDR_W'({idx, 2'b00});
    reg_hit = (addr == want);
  endfunction : reg_hit

  // Frame length follows the eight or nine data bit format.
  assign frame_len = s_ff.cfg[`ASFD_F_NINE] ? `ASFD_LEN9 : `ASFD_LEN8; // [R23]

  // Chooses what the idle shifter sends next: preamble, break or data.
  always_comb begin
    load_now = 1'b0;
    load_frame = `ASFD_FRAME_ONES;
    if (s_ff.ctrl[`ASFD_C_TX_ON] && !tx_busy) begin
      if (s_ff.preamble_pend) begin
        load_now = 1'b1;
      end else if (s_ff.ctrl[`ASFD_C_BREAK]) begin
        load_now = 1'b1; // [R7]
        load_frame = `ASFD_FRAME_ZERO;
      end else if (s_ff.tx_buf_full) begin
        load_now = 1'b1;
        if (s_ff.cfg[`ASFD_F_NINE]) begin
          load_frame = {1'b1, s_ff.tx_ninth, s_ff.tx_buf, 1'b0}; // [R20]
        end else begin
          load_frame = {2'b11, s_ff.tx_buf, 1'b0};
        end
      end
    end
  end

  asfd_tx_shifter u_tx (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .bit_tick(bit_tick),
    .transmitter_on(s_ff.ctrl[`ASFD_C_TX_ON]),
    .load(load_now),
    .frame(load_frame),
    .frame_len(frame_len),
    .busy(tx_busy),
    .txd(txd_out),
    .txd_oe_n(txd_oe_n)
  );

  asfd_quiet_detect u_quiet (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .enable(s_ff.ctrl[`ASFD_C_RX_ON]),
    .bit_tick(bit_tick),
    .rxd(rxd),
    .frame_len(frame_len),
    .quiet_pulse(quiet_pulse)
  );

  // Register access, flag set and clear, buffers and interrupt.
  always_comb begin
    logic accept;
    logic rd_acc;
    logic wr_acc;
    logic [7:0] set_f;
    logic [7:0] clr_f;
    logic [7:0] rmux;
    logic par_err;
    accept = 1'b0;
    rd_acc = 1'b0;
    wr_acc = 1'b0;
    set_f = 8'h00;
    clr_f = 8'h00;
    rmux = 8'h00;
    par_err = 1'b0;
    nxt_s = s_ff;

    // Slave handshake: waitrequest drops one cycle after a request.
    accept = (avs_read || avs_write) && !s_ff.waitreq;
    rd_acc = accept && avs_read;
    wr_acc = accept && avs_write && avs_byteenable[0];
    nxt_s.waitreq = 1'b1;

    // Read multiplexer; unmapped addresses read zero.
    if (reg_hit(avs_address, `ASFD_IDX_CFG)) begin
      rmux = s_ff.cfg;
    end else if (reg_hit(avs_address, `ASFD_IDX_CTRL)) begin
      rmux = s_ff.ctrl; // [R1]
    end else if (reg_hit(avs_address, `ASFD_IDX_STAT1)) begin
      rmux = s_ff.flags; // [R8]
    end else if (reg_hit(avs_address, `ASFD_IDX_STAT2)) begin
      rmux = {7'h00, s_ff.rx_active}; // [R18]
    end else if (reg_hit(avs_address, `ASFD_IDX_DHI)) begin
      rmux = {s_ff.rx_buf[8], s_ff.tx_ninth, 6'h00}; // [R19] [R20]
    end else if (reg_hit(avs_address, `ASFD_IDX_DLO)) begin
      rmux = s_ff.rx_buf[7:0]; // [R19]
    end
    // Read data is captured for reads only, so it holds across writes.
    if ((avs_read || avs_write) && s_ff.waitreq) begin
      nxt_s.waitreq = 1'b0;
      if (avs_read) begin
        nxt_s.rdata = {24'h000000, rmux};
      end
    end

    // A status read arms exactly the flags it returned as set.
    if (rd_acc && reg_hit(avs_address, `ASFD_IDX_STAT1)) begin
      nxt_s.armed = s_ff.rdata[7:0]; // [R9] [R10] [R11]
    end

    // Data read completes the receive flag clearing sequence.
    if (rd_acc && reg_hit(avs_address, `ASFD_IDX_DLO)) begin
      clr_f = s_ff.armed & `ASFD_RX_MASK; // [R11] [R14] [R15] [R16]
      nxt_s.armed = s_ff.armed & ~`ASFD_RX_MASK;
    end

    // Data writes load the transmit buffer; only the low-byte write clears armed transmit flags.
    if (wr_acc && reg_hit(avs_address, `ASFD_IDX_DHI)) begin
      nxt_s.tx_ninth = avs_writedata[`ASFD_D_TX9];
    end
    if (wr_acc && reg_hit(avs_address, `ASFD_IDX_DLO)) begin
      nxt_s.tx_buf = avs_writedata[7:0]; // [R19]
      nxt_s.tx_buf_full = s_ff.ctrl[`ASFD_C_TX_ON];
      clr_f = clr_f | (s_ff.armed & `ASFD_TX_MASK); // [R9] [R10]
      nxt_s.armed = nxt_s.armed & ~`ASFD_TX_MASK;
    end

    // Frame format register.
    if (wr_acc && reg_hit(avs_address, `ASFD_IDX_CFG)) begin
      nxt_s.cfg = avs_writedata[7:0];
    end

    // Quiet line ends wakeup wait, or else raises the quiet flag.
    if (quiet_pulse) begin
      if (s_ff.ctrl[`ASFD_C_WAKE]) begin
        nxt_s.ctrl[`ASFD_C_WAKE] = 1'b0; // [R6] [R12]
      end else begin
        set_f[`ASFD_S_IDLE] = 1'b1; // [R12]
      end
    end

    // Control writes; a software write wins over the wakeup release.
    if (wr_acc && reg_hit(avs_address, `ASFD_IDX_CTRL)) begin
      nxt_s.ctrl = avs_writedata[7:0]; // [R1]
      if (avs_writedata[`ASFD_C_TX_ON] && !s_ff.ctrl[`ASFD_C_TX_ON]) begin
        set_f[`ASFD_S_TXE] = 1'b1; // [R21]
        set_f[`ASFD_S_TXC] = 1'b1;
        nxt_s.preamble_pend = 1'b1;
      end
    end

    // Disabled transmitter drops anything still queued.
    if (!nxt_s.ctrl[`ASFD_C_TX_ON]) begin
      nxt_s.tx_buf_full = 1'b0; // [R22]
      nxt_s.preamble_pend = 1'b0;
    end

    // Shifter hand-off empties the buffer or retires the preamble.
    if (load_now) begin
      if (s_ff.preamble_pend) begin
        nxt_s.preamble_pend = 1'b0;
      end else if (!s_ff.ctrl[`ASFD_C_BREAK]) begin
        nxt_s.tx_buf_full = 1'b0;
        set_f[`ASFD_S_TXE] = 1'b1; // [R9]
      end
    end

    // Shifter going idle with nothing to send completes the queue.
    nxt_s.tx_busy_d = tx_busy;
    if (s_ff.tx_busy_d && !tx_busy && !load_now) begin
      set_f[`ASFD_S_TXC] = 1'b1; // [R10]
      if (!s_ff.ctrl[`ASFD_C_TX_ON]) begin
        set_f[`ASFD_S_TXE] = 1'b1; // [R22]
      end
    end

    // Received character: transfer, or overrun when the buffer is held.
    par_err = (s_ff.cfg[`ASFD_F_NINE] ? ^rx_char_bits : ^rx_char_bits[7:0]) ^ s_ff.cfg[`ASFD_F_PODD];
    if (rx_char_strobe && s_ff.ctrl[`ASFD_C_RX_ON] && !s_ff.ctrl[`ASFD_C_WAKE]) begin
      if (s_ff.flags[`ASFD_S_RXF] || s_ff.flags[`ASFD_S_FRAME]) begin
        set_f[`ASFD_S_OR] = 1'b1; // [R13]
      end else begin
        nxt_s.rx_buf = s_ff.cfg[`ASFD_F_NINE] ? rx_char_bits : {1'b0, rx_char_bits[7:0]}; // [R20]
        set_f[`ASFD_S_RXF] = 1'b1; // [R11]
        set_f[`ASFD_S_NOISE] = rx_char_noise; // [R14]
        set_f[`ASFD_S_FRAME] = !rx_char_stop_bit; // [R15]
        set_f[`ASFD_S_PARITY] = s_ff.cfg[`ASFD_F_PEN] && par_err; // [R16]
      end
    end

    // Flags: a set in the same cycle as its clear wins.
    nxt_s.flags = (s_ff.flags & ~clr_f) | set_f; // [R8]
    nxt_s.rx_active = rx_busy; // [R18]

    // One level request; noise, framing and parity take no part.
    nxt_s.irq = (s_ff.flags[`ASFD_S_TXE] && s_ff.ctrl[`ASFD_C_TXE_IEN]) // [R2]
      || (s_ff.flags[`ASFD_S_TXC] && s_ff.ctrl[`ASFD_C_TXC_IEN]) // [R3]
      || (s_ff.ctrl[`ASFD_C_RX_IEN] && !s_ff.ctrl[`ASFD_C_WAKE]
          && (s_ff.flags[`ASFD_S_RXF] || s_ff.flags[`ASFD_S_OR])) // [R4] [R6]
      || (s_ff.flags[`ASFD_S_IDLE] && s_ff.ctrl[`ASFD_C_QUIET_IEN]); // [R5] [R17] [R25]
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '{ctrl: `ASFD_RST_CTRL, cfg: `ASFD_RST_CFG, flags: `ASFD_RST_STAT1, armed: 8'h00,
                rx_buf: 9'h000, tx_buf: 8'h00, tx_ninth: 1'b0, tx_buf_full: 1'b0,
                preamble_pend: 1'b0, tx_busy_d: 1'b0, rx_active: 1'b0, irq: 1'b0,
                waitreq: 1'b1, rdata: 32'h00000000}; // [R1] [R8]
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign avs_readdata = s_ff.rdata;
  assign avs_waitrequest = s_ff.waitreq;
  assign irq = s_ff.irq;

endmodule : asfd_top

/* bench/asfd_top_checker.sv */
/*
  Port-level assertions for the serial flag and data block.
  Assumes it is bound into asfd_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`include "asfd_regs.svh"

module asfd_top_checker #(
  parameter int ADDR_W = 10
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic bit_tick,
  input wire logic txd_out,
  input wire logic txd_oe_n,
  input wire logic irq
);
  localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'({`ASFD_IDX_CTRL, 2'b00});
  logic [7:0] ctrl_sh;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Shadow of the enable-control register, taken at the edge where a write completes.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_sh <= 8'h00;
    end else if (clk_en && avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == CTRL_ADDR) begin
      ctrl_sh <= avs_writedata[7:0];
    end
  end

  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest && clk_en;
  endsequence
  sequence bus_ack;
    !avs_waitrequest;
  endsequence

  wait_one_a: assert property (bus_req |=> bus_ack) else $error("request not answered next cycle");
  wait_pulse_a: assert property (bus_ack and clk_en |=> avs_waitrequest) else $error("waitrequest low too long");
  idle_wait_a: assert property (!avs_read && !avs_write && clk_en |=> avs_waitrequest) else $error("answer without request");
  read_upper_a: assert property (bus_ack |-> avs_readdata[31:8] == 24'h0) else $error("read data upper bits set");
  read_hold_a: assert property ($changed(avs_readdata) |-> $fell(avs_waitrequest) && avs_read) else $error("read data moved");
  irq_masked_a: assert property (ctrl_sh[7:4] == 4'h0 && $past(ctrl_sh[7:4]) == 4'h0 |-> !irq) else $error("irq while masked");
  oe_release_a: assert property ($rose(txd_oe_n) |-> $past(bit_tick)) else $error("pin released off tick");
  txd_tick_a: assert property ($changed(txd_out) |-> $past(bit_tick)) else $error("line moved off tick");
  idle_level_a: assert property (txd_oe_n |-> txd_out) else $error("released pin not high");
endmodule : asfd_top_checker

bind asfd_top asfd_top_checker #(.ADDR_W(ADDR_W)) u_chk (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .bit_tick(bit_tick), .txd_out(txd_out), .txd_oe_n(txd_oe_n), .irq(irq));

/* bench/asfd_far_end.sv */
/*
  Far-end model: bit-rate divider and a receiver that decodes the transmit line.
  Assumes eight-bit frames while transmitting.
*/
`timescale 1ns/100ps

module asfd_far_end #(
  parameter int TICK_DIV = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic txd,
  output logic bit_tick,
  output logic [7:0] last_byte,
  output int frames,
  output int breaks
);
  int div;
  int pos;
  logic [7:0] sh;

  // Free-running divider making a one-cycle tick per bit time.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div <= 0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= (div == TICK_DIV - 1);
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
    end
  end

  // Samples one bit per tick: start, eight data bits LSB first, stop.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pos <= 0;
      sh <= 8'h00;
      frames <= 0;
      breaks <= 0;
      last_byte <= 8'h00;
    end else if (bit_tick) begin
      if (pos == 0) begin
        pos <= txd ? 0 : 1;
      end else if (pos <= 8) begin
        sh <= {txd, sh[7:1]};
        pos <= pos + 1;
      end else begin
        pos <= 0;
        if (txd) begin
          frames <= frames + 1;
          last_byte <= sh;
        end else if (sh == 8'h00) begin
          breaks <= breaks + 1;
        end
      end
    end
  end
endmodule : asfd_far_end

/* bench/test_async_serial_flags_and_data.sv */
/*
  Self-checking bench for the serial flag and data block.
  Assumes the far-end model supplies the bit tick and decodes the line.
*/
`timescale 1ns/100ps
`include "asfd_regs.svh"

module test_async_serial_flags_and_data;
  import asfd_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic bit_tick;
  logic rxd = 1'b1;
  logic rx_char_strobe = 1'b0;
  logic [8:0] rx_char_bits = 9'h000;
  logic rx_char_noise = 1'b0;
  logic rx_char_stop_bit = 1'b1;
  logic rx_busy = 1'b0;
  logic txd_out;
  logic txd_oe_n;
  logic irq;
  logic [7:0] last_byte;
  logic [7:0] v;
  int frames;
  int breaks;
  int failures = 0;
  int checked = 0;

  asfd_top dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_tick(bit_tick), .rxd(rxd),
    .rx_char_strobe(rx_char_strobe), .rx_char_bits(rx_char_bits), .rx_char_noise(rx_char_noise),
    .rx_char_stop_bit(rx_char_stop_bit), .rx_busy(rx_busy), .txd_out(txd_out), .txd_oe_n(txd_oe_n), .irq(irq));
  asfd_far_end u_far (.clock(clock), .reset_n(reset_n), .txd(txd_out), .bit_tick(bit_tick),
    .last_byte(last_byte), .frames(frames), .breaks(breaks));

  // Clock of 4 ns period.
  always #2 clock = ~clock;

  task automatic complete_run();
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, wd};
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      $display("ERROR bus_answer expected 0 seen %b", avs_waitrequest);
    end
    v = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~avs_writedata;
  endtask : bus

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk($sformatf("reg_%h", idx), v, exp);
  endtask : rdc

  task automatic irqc(input logic exp);
    repeat (3) @(posedge clock);
    chk("irq", {7'h0, irq}, {7'h0, exp});
  endtask : irqc

  task automatic send_char(input logic [8:0] bits, input logic noise, input logic stop);
    @(posedge clock);
    rx_char_strobe <= 1'b1;
    rx_char_bits <= bits;
    rx_char_noise <= noise;
    rx_char_stop_bit <= stop;
    @(posedge clock);
    rx_char_strobe <= 1'b0;
    rx_char_bits <= ~bits;
    rx_char_noise <= !noise;
    rx_char_stop_bit <= !stop;
  endtask : send_char

  task automatic t_reset_values();
    rdc(`ASFD_IDX_CTRL, 8'h00);
    rdc(`ASFD_IDX_STAT1, 8'hc0);
    rdc(`ASFD_IDX_STAT2, 8'h00);
    rdc(8'h10, 8'h00);
    bus(1'b1, `ASFD_IDX_STAT1, 8'h00);
    rdc(`ASFD_IDX_STAT1, 8'hc0);
  endtask : t_reset_values

  task automatic t_transmit();
    bus(1'b1, `ASFD_IDX_CTRL, 8'h0c);
    rdc(`ASFD_IDX_STAT1, 8'hc0);
    bus(1'b1, `ASFD_IDX_DHI, 8'h7f);
    bus(1'b1, `ASFD_IDX_DLO, 8'ha5);
    rdc(`ASFD_IDX_STAT1, 8'h00);
    for (int i = 0; i < 400 && frames < 1; i++) @(posedge clock);
    chk("line_byte", last_byte, 8'ha5);
    repeat (24) @(posedge clock);
    rdc(`ASFD_IDX_STAT1, 8'hc0);
    bus(1'b1, `ASFD_IDX_CTRL, 8'h8c);
    irqc(1'b1);
    bus(1'b1, `ASFD_IDX_CTRL, 8'h4c);
    irqc(1'b1);
    bus(1'b1, `ASFD_IDX_CTRL, 8'h0c);
    irqc(1'b0);
  endtask : t_transmit

  task automatic t_break_and_stop();
    bus(1'b1, `ASFD_IDX_CTRL, 8'h0d);
    for (int i = 0; i < 400 && breaks < 1; i++) @(posedge clock);
    chk("break_seen", {7'h0, breaks > 0}, 8'h01);
    bus(1'b1, `ASFD_IDX_CTRL, 8'h00);
    for (int i = 0; i < 400 && txd_oe_n !== 1'b1; i++) @(negedge clock);
    chk("pin_released", {7'h0, txd_oe_n}, 8'h01);
    rdc(`ASFD_IDX_STAT1, 8'hc0);
  endtask : t_break_and_stop

  task automatic t_receive();
    bus(1'b1, `ASFD_IDX_CFG, 8'h13);
    bus(1'b1, `ASFD_IDX_CTRL, 8'h24);
    send_char(9'h181, 1'b1, 1'b1);
    irqc(1'b1);
    send_char(9'h0ff, 1'b0, 1'b1);
    rdc(`ASFD_IDX_STAT1, 8'hec);
    rdc(`ASFD_IDX_DHI, 8'hc0);
    rdc(`ASFD_IDX_DLO, 8'h81);
    rdc(`ASFD_IDX_STAT1, 8'hc0);
    irqc(1'b0);
    send_char(9'h055, 1'b0, 1'b0);
    rdc(`ASFD_IDX_STAT1, 8'he3);
    bus(1'b1, `ASFD_IDX_CTRL, 8'h26);
    irqc(1'b0);
    rdc(`ASFD_IDX_DLO, 8'h55);
    rdc(`ASFD_IDX_STAT1, 8'hc0);
  endtask : t_receive

  task automatic t_line_quiet();
    bus(1'b1, `ASFD_IDX_CTRL, 8'h14);
    rxd <= 1'b0;
    repeat (16) @(posedge clock);
    rxd <= 1'b1;
    repeat (104) @(posedge clock);
    rdc(`ASFD_IDX_STAT1, 8'hd0);
    irqc(1'b1);
    bus(1'b0, `ASFD_IDX_DLO, 8'h00);
    repeat (104) @(posedge clock);
    rdc(`ASFD_IDX_STAT1, 8'hc0);
    irqc(1'b0);
    bus(1'b1, `ASFD_IDX_CTRL, 8'h06);
    rxd <= 1'b0;
    repeat (16) @(posedge clock);
    rxd <= 1'b1;
    repeat (104) @(posedge clock);
    rdc(`ASFD_IDX_CTRL, 8'h04);
    rdc(`ASFD_IDX_STAT1, 8'hc0);
    rx_busy <= 1'b1;
    rdc(`ASFD_IDX_STAT2, 8'h01);
    rx_busy <= 1'b0;
    rdc(`ASFD_IDX_STAT2, 8'h00);
  endtask : t_line_quiet

  // Watchdog cutting a hung run short.
  initial begin
    #200000;
    failures++;
    complete_run();
  end

  // Main sequence: reset for three cycles, then every scenario in turn.
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    t_reset_values();
    t_transmit();
    t_break_and_stop();
    t_receive();
    t_line_quiet();
    complete_run();
  end
endmodule : test_async_serial_flags_and_data
